// [rda_ctrl.sv]
`timescale 1ns/100ps
// What this block does
// (R01) Listener mode: stay quiet, act on received data
// (R02) Sender mode: transmit value continuously, unprompted
// (R03) Differential link: accept only own address 0..99
// (R04) Held alarm stays active until cleared
// (R05) Menu plus up/down press clears held alarm
// (R06) Bit rate selectable, 300 to 19200
// (R07) Seven bits with odd or even parity
// (R08) Eight bits, no parity, one stop
// (R09) No flow control on the link
// (R10) Two alarms: enable, type, hold, clamped setpoints
// (R11) Display takes alarm colour while triggered
// (R12) Colours red, green or amber
// (R13) Four seven-segment decimal digits
// (R14) Link standard selects whether addressing applies
// (R15) Colour updates on every alarm trigger
// (R16) High above setpoint, low below, or both
// (R17) Not held: alarm follows comparison directly
module rda_ctrl import rda_pkg::*; #(
  parameter int CLK_FREQ = CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ser_rxd,
  output logic ser_txd,
  output logic ser_drv_en,
  input wire logic btn_menu,
  input wire logic btn_up,
  input wire logic btn_down,
  output logic [27:0] digit_segs,
  output logic [1:0] disp_colour,
  output logic [1:0] alarm_out,
  output logic irq
);
  // Slowest divider must fit the counter, fastest must leave a few cycles
  if (CLK_FREQ / RATE_BPS[0] >= (1 << CNT_W) || CLK_FREQ / RATE_BPS[6] < 4) begin : g_chk
    $error("CLK_FREQ does not suit the bit counter");
  end

  logic [15:0] ctrl_r, cfg_r;
  logic [31:0] sp_r [2];
  logic [16:0] value_r, tx_val_r;
  logic [3:0] int_stat_r, int_en_r, int_ev;
  logic [31:0] prdata_r, rd_mux;
  logic [3:0] pin_meta_r, pin_sync_r;
  logic [1:0] btn_prev_r, alm_r, alm_nxt, cond;
  logic [1:0] colour_r, colour_nxt;
  rda_rx_state_t rx_st_r;
  rda_parse_state_t ps_r;
  logic [CNT_W-1:0] rx_cnt_r, tx_cnt_r, bit_cyc;
  logic [2:0] rx_bits_r, tx_idx_r;
  logic [7:0] rx_sh_r, rx_byte_r, rx_char, tx_char;
  logic rx_done_r, rx_bad_r, addr_n_r, neg_r, tx_busy_r, tx_b7;
  logic [3:0] tx_bits_r;
  logic [9:0] tx_sh_r;
  logic [15:0] bcd_r;
  logic [6:0] addr_acc_r;

  // Control fields
  wire logic listen = ctrl_r[CTRL_LISTEN_BIT];
  wire logic diff = ctrl_r[CTRL_DIFF_BIT];
  wire logic held = ctrl_r[CTRL_HELD_BIT];
  wire logic [1:0] fmt = ctrl_r[CTRL_FMT_LSB +: 2];
  wire logic [2:0] rate_sel = ctrl_r[CTRL_RATE_LSB +: 3];
  wire logic [6:0] dev_addr = ctrl_r[CTRL_ADDR_LSB +: 7];

  // APB decode; zero wait states keep the master simple
  wire logic acc = psel & penable;
  wire logic setup = psel & ~penable;
  wire logic hit_ctrl = paddr == OFF_CTRL;
  wire logic hit_cfg = paddr == OFF_ALM_CFG;
  wire logic hit_sp1 = paddr == OFF_SP1;
  wire logic hit_sp2 = paddr == OFF_SP2;
  wire logic hit_val = paddr == OFF_VALUE;
  wire logic hit_stat = paddr == OFF_STATUS;
  wire logic hit_ist = paddr == OFF_INT_STAT;
  wire logic hit_iclr = paddr == OFF_INT_CLR;
  wire logic hit_ien = paddr == OFF_INT_EN;
  wire logic mapped = hit_ctrl | hit_cfg | hit_sp1 | hit_sp2 | hit_val | hit_stat | hit_ist
                      | hit_iclr | hit_ien;
  wire logic wr = acc & pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_r;

  // Setpoints clamp into the displayable range
  function automatic logic [15:0] sat(input logic [15:0] x);
    if ($signed(x) < SP_MIN) begin
      return SP_MIN;
    end else if ($signed(x) > SP_MAX) begin
      return SP_MAX;
    end
    return x;
  endfunction : sat

  // Out-of-range rate or address writes saturate
  wire logic [2:0] rate_w = (pwdata[CTRL_RATE_LSB +: 3] > RATE_MAX_SEL) ? RATE_MAX_SEL
                            : pwdata[CTRL_RATE_LSB +: 3];
  wire logic [6:0] addr_w = (pwdata[CTRL_ADDR_LSB +: 7] > ADDR_MAX) ? ADDR_MAX
                            : pwdata[CTRL_ADDR_LSB +: 7];
  wire logic [15:0] ctrl_w = {1'b0, addr_w, rate_w, pwdata[CTRL_FMT_LSB +: 2],
                              pwdata[2:0]};

  assign rd_mux = hit_ctrl ? {16'h0000, ctrl_r}
                : hit_cfg ? {16'h0000, cfg_r}
                : hit_sp1 ? sp_r[0]
                : hit_sp2 ? sp_r[1]
                : hit_val ? {15'h0000, value_r}
                : hit_stat ? {26'h000_0000, tx_busy_r, listen, colour_r, alm_r}
                : hit_ist ? {28'h000_0000, int_stat_r}
                : hit_ien ? {28'h000_0000, int_en_r} : 32'h0000_0000;

  // Configuration registers
  // (R10) alarm setup
  // (R14) link standard
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      cfg_r <= ALM_CFG_RST;
      sp_r[0] <= SP_RST;
      sp_r[1] <= SP_RST;
      int_en_r <= 4'h0;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (wr && hit_ctrl) ctrl_r <= ctrl_w;
      if (wr && hit_cfg) cfg_r <= {1'b0, pwdata[14:0]};
      if (wr && hit_sp1) sp_r[0] <= {sat(pwdata[31:16]), sat(pwdata[15:0])};
      if (wr && hit_sp2) sp_r[1] <= {sat(pwdata[31:16]), sat(pwdata[15:0])};
      if (wr && hit_ien) int_en_r <= pwdata[3:0];
      if (setup) prdata_r <= rd_mux;
    end
  end

  // Pins pass two flops: {down, up, menu, rxd}; rxd idles high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r <= 4'h1;
      pin_sync_r <= 4'h1;
      btn_prev_r <= 2'h0;
    end else begin
      pin_meta_r <= {btn_down, btn_up, btn_menu, ser_rxd};
      pin_sync_r <= pin_meta_r;
      btn_prev_r <= pin_sync_r[3:2];
    end
  end
  wire logic rxd_s = pin_sync_r[0];
  // (R05) menu held, then up or down press
  wire logic alm_clr = pin_sync_r[1] & |(pin_sync_r[3:2] & ~btn_prev_r);

  // (R06) divider from selected rate
  assign bit_cyc = CNT_W'(CLK_FREQ / RATE_BPS[rate_sel]);

  // Receiver: half-bit to centre, then one sample per bit
  // (R09) no pacing, every frame is taken as it comes
  // (R01) receiver starts a frame only when listening
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= '0;
      rx_bits_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_byte_r <= 8'h00;
      rx_done_r <= 1'b0;
      rx_bad_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      if (rx_cnt_r != '0) rx_cnt_r <= rx_cnt_r - 1'b1;
      case (rx_st_r)
        RX_IDLE: if (!rxd_s && listen) begin
          rx_cnt_r <= bit_cyc >> 1;
          rx_st_r <= RX_START;
        end
        RX_START: if (rx_cnt_r == '0) begin
          rx_st_r <= rxd_s ? RX_IDLE : RX_DATA;
          rx_cnt_r <= bit_cyc - 1'b1;
          rx_bits_r <= 3'h0;
        end
        RX_DATA: if (rx_cnt_r == '0) begin
          rx_sh_r <= {rxd_s, rx_sh_r[7:1]};
          rx_bits_r <= rx_bits_r + 3'h1;
          rx_cnt_r <= bit_cyc - 1'b1;
          if (rx_bits_r == 3'h7) rx_st_r <= RX_STOP;
        end
        RX_STOP: if (rx_cnt_r == '0) begin
          rx_done_r <= 1'b1;
          rx_byte_r <= rx_sh_r;
          // (R07) parity check
          rx_bad_r <= !rxd_s || (fmt == FMT_7O1 && !(^rx_sh_r))
                      || (fmt == FMT_7E1 && (^rx_sh_r));
          rx_st_r <= RX_IDLE;
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // (R08) eight data bits pass whole, else bit 7 is parity
  assign rx_char = (fmt == FMT_8N1) ? rx_byte_r : {1'b0, rx_byte_r[6:0]};
  wire logic is_dig = rx_char[7:4] == CH_DIGIT_HI && rx_char[3:0] <= 4'h9;
  wire logic rx_ok = rx_done_r && !rx_bad_r && listen;
  wire logic commit = rx_ok && ps_r == PS_VAL && rx_char == CH_CR;
  // (R03) address only matters on the differential link
  wire logic addr_match = !diff || addr_acc_r == dev_addr;
  wire logic commit_ok = commit && addr_match;

  // Message parser: [#dd] [-] digits CR
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_r <= PS_IDLE;
      addr_acc_r <= 7'h00;
      addr_n_r <= 1'b0;
      bcd_r <= 16'h0000;
      neg_r <= 1'b0;
    end else if (rx_done_r && (!rx_ok)) begin
      ps_r <= PS_IDLE;
    end else if (rx_ok) begin
      case (ps_r)
        PS_IDLE: if (diff && rx_char == CH_ADDR) begin
          ps_r <= PS_ADDR;
          addr_acc_r <= 7'h00;
          addr_n_r <= 1'b0;
        end else if (!diff && (is_dig || rx_char == CH_MINUS)) begin
          ps_r <= PS_VAL;
          bcd_r <= is_dig ? {12'h000, rx_char[3:0]} : 16'h0000;
          neg_r <= !is_dig;
        end
        PS_ADDR: if (is_dig) begin
          addr_acc_r <= 7'((addr_acc_r * 10) + rx_char[3:0]);
          addr_n_r <= 1'b1;
          if (addr_n_r) begin
            ps_r <= PS_VAL;
            bcd_r <= 16'h0000;
            neg_r <= 1'b0;
          end
        end else begin
          ps_r <= PS_IDLE;
        end
        PS_VAL: if (is_dig) begin
          bcd_r <= {bcd_r[11:0], rx_char[3:0]};
        end else if (rx_char == CH_MINUS) begin
          neg_r <= 1'b1;
        end else begin
          ps_r <= PS_IDLE;
        end
        default: ps_r <= PS_IDLE;
      endcase
    end
  end

  // (R13) negative values keep three digits; received data beats a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_r <= VALUE_RST;
    end else if (commit_ok) begin
      value_r <= {neg_r, neg_r ? {4'h0, bcd_r[11:0]} : bcd_r};
    end else if (wr && hit_val) begin
      value_r <= pwdata[16:0];
    end
  end

  // Signed binary of the shown value for comparison
  wire logic signed [15:0] mag = 16'(value_r[15:12] * 1000 + value_r[11:8] * 100
                                     + value_r[7:4] * 10 + value_r[3:0]);
  wire logic signed [15:0] val_bin = value_r[VALUE_NEG_BIT] ? -mag : mag;

  // Alarm evaluation, one per generate pass
  for (genvar i = 0; i < 2; i++) begin : g_alm
    wire logic [7:0] c = cfg_r[i * ALM_STRIDE +: 8];
    wire logic [1:0] typ = c[ALM_TYPE_LSB +: 2];
    wire logic hi = val_bin > $signed(sp_r[i][SP_HI_LSB +: 16]);
    wire logic lo = val_bin < $signed(sp_r[i][SP_LO_LSB +: 16]);
    // (R16) compare type selection
    assign cond[i] = ((typ == CMP_HIGH || typ == CMP_BOTH) && hi)
                     || ((typ == CMP_LOW || typ == CMP_BOTH) && lo);
    // (R04) held alarm, a new trigger beats the clear
    // (R17) not held follows the comparison
    assign alm_nxt[i] = c[ALM_EN_BIT] && (cond[i] || (held && alm_r[i] && !alm_clr));
  end

  // (R11) alarm colour, first alarm has priority
  // (R12) two-bit colour codes
  assign colour_nxt = alm_r[0] ? cfg_r[ALM_COL_LSB +: 2]
                    : alm_r[1] ? cfg_r[ALM_STRIDE + ALM_COL_LSB +: 2]
                    : cfg_r[NORMAL_COL_LSB +: 2];
  assign int_ev = {rx_done_r && rx_bad_r && listen, commit_ok, alm_nxt & ~alm_r};

  // (R15) colour register follows alarm state every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alm_r <= 2'h0;
      colour_r <= ALM_CFG_RST[NORMAL_COL_LSB +: 2];
      int_stat_r <= 4'h0;
    end else begin
      alm_r <= alm_nxt;
      colour_r <= colour_nxt;
      // Set wins over a clear in the same cycle
      int_stat_r <= (int_stat_r & ~((wr && hit_iclr) ? pwdata[3:0] : 4'h0)) | int_ev;
    end
  end
  assign disp_colour = colour_r;
  assign alarm_out = alm_r;
  assign irq = |(int_stat_r & int_en_r);

  // Sender character: sign or top digit, three digits, CR
  assign tx_char = (tx_idx_r == 3'h0) ? (tx_val_r[VALUE_NEG_BIT] ? CH_MINUS
                                         : {CH_DIGIT_HI, tx_val_r[15:12]})
                 : (tx_idx_r == 3'h1) ? {CH_DIGIT_HI, tx_val_r[11:8]}
                 : (tx_idx_r == 3'h2) ? {CH_DIGIT_HI, tx_val_r[7:4]}
                 : (tx_idx_r == 3'h3) ? {CH_DIGIT_HI, tx_val_r[3:0]} : CH_CR;
  // (R07) parity bit, or eighth data bit
  assign tx_b7 = (fmt == FMT_8N1) ? tx_char[7]
               : (fmt == FMT_7O1) ? ~^tx_char[6:0] : ^tx_char[6:0];

  // Transmitter; a frame in flight finishes even if the mode changes
  // (R02) sender restarts at once after each frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= 10'h3ff;
      tx_bits_r <= 4'h0;
      tx_cnt_r <= '0;
      tx_idx_r <= 3'h0;
      tx_val_r <= VALUE_RST;
    end else if (!tx_busy_r) begin
      if (!listen) begin
        tx_busy_r <= 1'b1;
        tx_sh_r <= {1'b1, tx_b7, tx_char[6:0], 1'b0};
        tx_bits_r <= 4'h0;
        tx_cnt_r <= bit_cyc - 1'b1;
      end else begin
        // Idle listener keeps a fresh snapshot, so a new sender starts current
        tx_val_r <= value_r;
        tx_idx_r <= 3'h0;
      end
    end else if (tx_cnt_r != '0) begin
      tx_cnt_r <= tx_cnt_r - 1'b1;
    end else if (tx_bits_r == 4'h9) begin
      tx_busy_r <= 1'b0;
      tx_idx_r <= (tx_idx_r == 3'h4) ? 3'h0 : tx_idx_r + 3'h1;
      if (tx_idx_r == 3'h4) tx_val_r <= value_r;
    end else begin
      tx_sh_r <= {1'b1, tx_sh_r[9:1]};
      tx_bits_r <= tx_bits_r + 4'h1;
      tx_cnt_r <= bit_cyc - 1'b1;
    end
  end
  assign ser_txd = tx_sh_r[0];
  assign ser_drv_en = diff & tx_busy_r;

  // (R13) four registered digit drivers
  for (genvar d = 0; d < 4; d++) begin : g_dig
    rda_seg7 u_seg (
      .pclk(pclk),
      .presetn(presetn),
      .digit(value_r[d * 4 +: 4]),
      .minus(d == 3 && value_r[VALUE_NEG_BIT]),
      .segs(digit_segs[d * 7 +: 7])
    );
  end

  sequence s_hold_set;
    held && alm_r[0] && !alm_clr;
  endsequence
  sequence s_bad_frame;
    rx_done_r && rx_bad_r && listen;
  endsequence

  a_listen_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R01
    (listen && !tx_busy_r) |=> !tx_busy_r && ser_txd) else $error("sent while listening");
  a_host_sends: assert property (@(posedge pclk) disable iff (!presetn) // R02
    (!listen && !tx_busy_r) |=> tx_busy_r ##1 !ser_txd) else $error("sender stalled");
  a_addr_reject: assert property (@(posedge pclk) disable iff (!presetn) // R03
    (commit && diff && addr_acc_r != dev_addr && !(wr && hit_val)) |=> $stable(value_r))
    else $error("foreign address accepted");
  a_hold_alarm: assert property (@(posedge pclk) disable iff (!presetn) // R04
    (s_hold_set and cfg_r[ALM_EN_BIT]) |=> alm_r[0]) else $error("held alarm dropped");
  a_clear_held: assert property (@(posedge pclk) disable iff (!presetn) // R05
    (alm_clr && !cond[0]) |=> !alm_r[0]) else $error("held alarm not cleared");
  a_rx_parity: assert property (@(posedge pclk) disable iff (!presetn) // R07
    s_bad_frame |=> int_stat_r[INT_RXERR]) else $error("bad frame not flagged");
  a_alarm_colour: assert property (@(posedge pclk) disable iff (!presetn) // R11
    $rose(alm_r[0]) |=> disp_colour == $past(cfg_r[ALM_COL_LSB +: 2]))
    else $error("alarm colour not shown");
  a_high_trip: assert property (@(posedge pclk) disable iff (!presetn) // R16
    (cfg_r[ALM_EN_BIT] && cfg_r[ALM_TYPE_LSB +: 2] == CMP_HIGH
     && val_bin > $signed(sp_r[0][SP_HI_LSB +: 16])) |=> alm_r[0])
    else $error("high alarm missed");
  a_unheld_follow: assert property (@(posedge pclk) disable iff (!presetn) // R17
    (!held && !cond[0]) |=> !alm_r[0] ##1 (disp_colour != $past(cfg_r[ALM_COL_LSB +: 2])
    || $past(alm_r[1])
    || $past(cfg_r[NORMAL_COL_LSB +: 2]) == $past(cfg_r[ALM_COL_LSB +: 2])))
    else $error("unheld alarm stuck");
endmodule : rda_ctrl

// [rda_partner.sv]
`timescale 1ns/100ps
// Instrument at the far end of the serial link
module rda_partner import rda_pkg::*; #(
  parameter int BIT_CYC = 52
) (
  input wire logic pclk,
  input wire logic ser_txd,
  output logic ser_rxd
);
  // Line rests at the mark level between characters
  initial begin
    ser_rxd = 1'b1;
  end

  task automatic send_char(input logic [7:0] ch, input logic [1:0] fmt, input logic bad);
    logic par;
    logic [9:0] frame;
    par = (fmt == FMT_7O1) ? ~^ch[6:0] : ^ch[6:0];
    frame = {1'b1, (fmt == FMT_8N1) ? ch[7] : par ^ bad, ch[6:0], 1'b0};
    for (int i = 0; i < 10; i++) begin
      ser_rxd <= frame[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
  endtask : send_char

  // mid-bit sampling, so edge jitter is tolerated
  task automatic recv_char(output logic [7:0] ch);
    @(negedge ser_txd);
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge pclk);
      ch[i] = ser_txd;
    end
  endtask : recv_char
endmodule : rda_partner

// [rda_pkg.sv]
package rda_pkg;
  // Clock rate of pclk in hertz
  localparam int CLK_HZ = 200_000_000;
  localparam int CNT_W = 24;
  // Link bit rates in bits per second, selected by index
  localparam int RATE_BPS [7] = '{300, 600, 1200, 2400, 4800, 9600, 19200};
  localparam logic [2:0] RATE_MAX_SEL = 3'h6;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ALM_CFG = 8'h04;
  localparam logic [7:0] OFF_SP1 = 8'h08;
  localparam logic [7:0] OFF_SP2 = 8'h0c;
  localparam logic [7:0] OFF_VALUE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_INT_STAT = 8'h18;
  localparam logic [7:0] OFF_INT_CLR = 8'h1c;
  localparam logic [7:0] OFF_INT_EN = 8'h20;

  // Control register fields
  localparam int CTRL_LISTEN_BIT = 0;
  localparam int CTRL_DIFF_BIT = 1;
  localparam int CTRL_HELD_BIT = 2;
  localparam int CTRL_FMT_LSB = 3;
  localparam int CTRL_RATE_LSB = 5;
  localparam int CTRL_ADDR_LSB = 8;
  // Alarm configuration fields, second alarm sits ALM_STRIDE above the first
  localparam int ALM_EN_BIT = 0;
  localparam int ALM_TYPE_LSB = 1;
  localparam int ALM_COL_LSB = 3;
  localparam int ALM_STRIDE = 8;
  localparam int NORMAL_COL_LSB = 13;
  // Setpoint word: low half and high half
  localparam int SP_LO_LSB = 0;
  localparam int SP_HI_LSB = 16;
  localparam int VALUE_NEG_BIT = 16;
  // Interrupt bits
  localparam int INT_ALM1 = 0;
  localparam int INT_ALM2 = 1;
  localparam int INT_FRAME = 2;
  localparam int INT_RXERR = 3;

  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h00a1;
  localparam logic [15:0] ALM_CFG_RST = 16'h2000;
  localparam logic [31:0] SP_RST = 32'h0000_0000;
  localparam logic [16:0] VALUE_RST = 17'h0_0000;

  // Encodings
  localparam logic [1:0] FMT_7O1 = 2'h0;
  localparam logic [1:0] FMT_7E1 = 2'h1;
  localparam logic [1:0] FMT_8N1 = 2'h2;
  localparam logic [1:0] CMP_HIGH = 2'h0;
  localparam logic [1:0] CMP_LOW = 2'h1;
  localparam logic [1:0] CMP_BOTH = 2'h2;
  localparam logic [1:0] COL_RED = 2'h0;
  localparam logic [1:0] COL_GREEN = 2'h1;
  localparam logic [1:0] COL_AMBER = 2'h2;
  localparam logic [6:0] ADDR_MAX = 7'h63;
  localparam logic signed [15:0] SP_MIN = -16'sd999;
  localparam logic signed [15:0] SP_MAX = 16'sd9999;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_ADDR = 8'h23;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [3:0] CH_DIGIT_HI = 4'h3;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
  } rda_rx_state_t;
  typedef enum logic [2:0] {
    PS_IDLE = 3'b001, PS_ADDR = 3'b010, PS_VAL = 3'b100
  } rda_parse_state_t;
endpackage : rda_pkg

// [rda_seg7.sv]
`timescale 1ns/100ps
// One display digit: decimal digit or minus sign to seven segments {g,f,e,d,c,b,a}
module rda_seg7 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] digit,
  input wire logic minus,
  output logic [6:0] segs
);
  logic [6:0] segs_nxt;

  // Codes above nine show blank rather than garbage
  always_comb begin
    segs_nxt = 7'h00;
    if (minus) begin
      segs_nxt = 7'h40;
    end else begin
      case (digit)
        4'h0: segs_nxt = 7'h3f;
        4'h1: segs_nxt = 7'h06;
        4'h2: segs_nxt = 7'h5b;
        4'h3: segs_nxt = 7'h4f;
        4'h4: segs_nxt = 7'h66;
        4'h5: segs_nxt = 7'h6d;
        4'h6: segs_nxt = 7'h7d;
        4'h7: segs_nxt = 7'h07;
        4'h8: segs_nxt = 7'h7f;
        4'h9: segs_nxt = 7'h6f;
        default: segs_nxt = 7'h00;
      endcase
    end
  end

  // Registered segment drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      segs <= 7'h00;
    end else begin
      segs <= segs_nxt;
    end
  end
endmodule : rda_seg7

// [test_remote_display_alarm_serial_ctrl.sv]
`timescale 1ns/100ps
module test_remote_display_alarm_serial_ctrl import rda_pkg::*;;
  typedef struct packed {
    logic [15:0] cfg;
    logic [16:0] value;
    logic [1:0] alarm;
    logic [1:0] colour;
  } rda_row_t;
  // Short bit time keeps the run small: 1 MHz over 19200 gives 52 cycles
  localparam int BIT_CYC = 52;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic btn_menu = 1'b0;
  logic btn_up = 1'b0;
  logic btn_down = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, ser_rxd, ser_txd, ser_drv_en, irq, rd_e;
  logic [27:0] digit_segs;
  logic [1:0] disp_colour, alarm_out;
  logic [31:0] rd_q;
  logic [7:0] rx_ch [6];
  int fails = 0;
  int checks_done = 0;
  // Rows: high red, low amber, both red, disabled, second low amber, both alarms
  rda_row_t rows [9] = '{'{16'h2001, 17'h00600, 2'h1, 2'h0}, '{16'h2001, 17'h00500, 2'h0, 2'h1},
    '{16'h2013, 17'h00099, 2'h1, 2'h2}, '{16'h2013, 17'h00100, 2'h0, 2'h1},
    '{16'h2005, 17'h00501, 2'h1, 2'h0}, '{16'h2005, 17'h10005, 2'h1, 2'h0},
    '{16'h2004, 17'h00600, 2'h0, 2'h1}, '{16'h3300, 17'h10051, 2'h2, 2'h2},
    '{16'h3303, 17'h10051, 2'h3, 2'h0}};

  rda_ctrl #(.CLK_FREQ(1_000_000)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ser_rxd(ser_rxd), .ser_txd(ser_txd),
    .ser_drv_en(ser_drv_en), .btn_menu(btn_menu), .btn_up(btn_up), .btn_down(btn_down),
    .digit_segs(digit_segs), .disp_colour(disp_colour), .alarm_out(alarm_out), .irq(irq));
  rda_partner #(.BIT_CYC(BIT_CYC)) partner (.pclk(pclk), .ser_txd(ser_txd), .ser_rxd(ser_rxd));

  // Clock at 200 MHz
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer; an idle cycle after it keeps psel single-driven per step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic settle(input logic [1:0] exp);
    for (int n = 0; n < 8 && alarm_out !== exp; n++) @(posedge pclk);
    // Colour register trails the alarm by one edge
    @(posedge pclk);
  endtask : settle

  task automatic send_msg(input string s, input logic [1:0] fmt, input logic bad);
    for (int i = 0; i < s.len(); i++) partner.send_char(s[i], fmt, bad && i == 0);
    partner.send_char(CH_CR, fmt, 1'b0);
  endtask : send_msg

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // Watchdog well beyond the expected run of about 25000 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(OFF_SP1, 1'b1, 32'h01f4_0064);
    apb(OFF_SP2, 1'b1, 32'h270f_ffce);
    apb(OFF_INT_EN, 1'b1, 32'h3);
    foreach (rows[i]) begin
      apb(OFF_ALM_CFG, 1'b1, {16'h0, rows[i].cfg});
      apb(OFF_VALUE, 1'b1, {15'h0, rows[i].value});
      settle(rows[i].alarm);
      chk("alarm_out", {30'h0, alarm_out}, {30'h0, rows[i].alarm});
      chk("disp_colour", {30'h0, disp_colour}, {30'h0, rows[i].colour});
    end
    chk("digit_segs", {4'h0, digit_segs}, {4'h0, 7'h40, 7'h3f, 7'h6d, 7'h06});
    $display("test alarm rows done");
    // Sticky interrupts: raise, clear, mask
    chk("irq", {31'h0, irq}, 32'h1);
    apb(OFF_INT_STAT, 1'b0, 32'h0);
    chk("int_stat", rd_q, 32'h3);
    apb(OFF_INT_CLR, 1'b1, 32'h1);
    apb(OFF_INT_EN, 1'b1, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(OFF_INT_STAT, 1'b0, 32'h0);
    chk("int_stat", rd_q, 32'h2);
    apb(OFF_INT_CLR, 1'b1, 32'h2);
    $display("test interrupts done");
    // held alarm survives, cleared by menu plus up, then down
    apb(OFF_CTRL, 1'b1, 32'h00a5);
    apb(OFF_ALM_CFG, 1'b1, 32'h2001);
    for (int b = 0; b < 2; b++) begin
      apb(OFF_VALUE, 1'b1, 32'h0600);
      apb(OFF_VALUE, 1'b1, 32'h0100);
      settle(2'h0);
      chk("held alarm", {30'h0, alarm_out}, 32'h1);
      btn_menu <= 1'b1;
      repeat (4) @(posedge pclk);
      btn_up <= (b == 0);
      btn_down <= (b == 1);
      settle(2'h0);
      chk("cleared alarm", {30'h0, alarm_out}, 32'h0);
      btn_menu <= 1'b0;
      btn_up <= 1'b0;
      btn_down <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    $display("test held alarm done");
    // listener receives in each character format
    for (int f = 0; f < 3; f++) begin
      apb(OFF_CTRL, 1'b1, 32'h00c1 | (f << CTRL_FMT_LSB));
      send_msg($sformatf("789%0d", f), f[1:0], 1'b0);
      apb(OFF_VALUE, 1'b0, 32'h0);
      chk("value", rd_q, 32'h7890 + f);
      chk("ser_txd quiet", {31'h0, ser_txd}, 32'h1);
    end
    // differential link, own address only; corrupt parity dropped
    apb(OFF_CTRL, 1'b1, 32'h07c3);
    send_msg("#075678", FMT_7O1, 1'b0);
    send_msg("#081111", FMT_7O1, 1'b0);
    send_msg("#072222", FMT_7O1, 1'b1);
    apb(OFF_VALUE, 1'b0, 32'h0);
    chk("value addressed", rd_q, 32'h5678);
    apb(OFF_INT_STAT, 1'b0, 32'h0);
    chk("int_stat rx", rd_q, 32'hd);
    $display("test listener done");
    apb(OFF_VALUE, 1'b1, 32'h0042);
    fork
      apb(OFF_CTRL, 1'b1, 32'h00d0);
      for (int i = 0; i < 6; i++) partner.recv_char(rx_ch[i]);
    join
    foreach (rx_ch[i]) begin
      chk("tx char", {24'h0, rx_ch[i]}, {24'h0, 8'("0042\r0" >> (8 * (5 - i)))});
    end
    chk("ser_drv_en", {31'h0, ser_drv_en}, 32'h0);
    apb(OFF_CTRL, 1'b1, 32'h00c1);
    $display("test sender done");
    // Second reset in mid-run, then defaults and an unmapped address
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset outputs", {26'h0, alarm_out, disp_colour, irq, ser_txd}, 32'h5);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(OFF_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", rd_q, {16'h0, CTRL_RST});
    apb(OFF_ALM_CFG, 1'b0, 32'h0);
    chk("alm_cfg reset", rd_q, {16'h0, ALM_CFG_RST});
    apb(8'h24, 1'b0, 32'h0);
    chk("unmapped", {rd_e, rd_q[30:0]}, 32'h8000_0000);
    $display("test reset done");
    wrap_up();
  end
endmodule : test_remote_display_alarm_serial_ctrl
